//--- design/rlhm_consts.vh
`ifndef RLHM_CONSTS_VH
`define RLHM_CONSTS_VH

// Register offsets (byte addresses, Avalon word aligned)
`define RLHM_OFF_CTRL 4'h0
`define RLHM_OFF_STATUS 4'h4
`define RLHM_OFF_TUNE 4'h8
`define RLHM_OFF_COUNT 4'hC

// Event register offsets (interrupt block)
`define RLHM_OFF_EVT_STAT 5'h10
`define RLHM_OFF_EVT_CLR 5'h14
`define RLHM_OFF_EVT_EN 5'h18

// Control fields
`define RLHM_CTRL_SEL_LSB 0
`define RLHM_CTRL_SEL_W 4
`define RLHM_CTRL_REFERENCE_SELECT_BIT 4
`define RLHM_CTRL_RST_VAL 5'h10

// Event bits
`define RLHM_EVT_FAIL 0
`define RLHM_EVT_RECOVER 1
`define RLHM_EVT_W 2

// Tuning word
`define RLHM_TUNE_W 10
`define RLHM_TUNE_MID 10'h200
`define RLHM_TUNE_PPM 300

// Timing, ns and derived cycles at 100 MHz
`define RLHM_CLK_NS 10
`define RLHM_SLACK_NS 25
`define RLHM_SLACK_CYC ((`RLHM_SLACK_NS + `RLHM_CLK_NS - 1) / `RLHM_CLK_NS)
`define RLHM_ASSERT_MULT 2
`define RLHM_DEASSERT_MULT 12
// Loss limit: two reference periods of missing reference, in 1/24 units
`define RLHM_LOSS_X24 16'h0030

`endif

//--- design/rlhm_sync2.v
`timescale 1ns/1ns
// ==========================================
// Two-flop synchroniser for W independent bits
module rlhm_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // Asynchronous in, synchronous out
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);

  reg [W-1:0] meta_reg;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      meta_reg <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule

//--- design/rlhm_monitor.v
`timescale 1ns/1ns
// What this block does
// - On reference loss, tuning word freezes at its last value.
// - On reference loss, validity flag goes to failure.
// - Tuning steers only while divided reference is inside capture range.
// - Outside capture range the validity flag stays in failure.
// - Back inside capture range the failure indication clears.
// - Failure shown within two ratio windows plus 25 ns.
// - Clear waits at least twelve ratio windows plus 25 ns.
// - Tuning word spans about plus or minus 300 ppm.
// - Output loop is always clocked by the crystal, never the reference.
// - Phase error from fed-back output versus reference steers tuning.
// - Four-bit ratio select sets reference to crystal ratio.
// - Flag high while reference valid, low when failed or out of range.
// - Select high picks first reference, low picks second.
`include "rlhm_consts.vh"

module rlhm_monitor #(
  parameter WIN_XTAL = 16,
  parameter CAP_TOL = 2,
  parameter CNT_W = 12
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // Asynchronous pins
  input wire i_first_reference_in,
  input wire i_second_reference_in,
  input wire i_feedback_input,
  input wire i_crystal_input,
  // Loop clock and tuning
  output reg o_loop_clk,
  output reg [`RLHM_TUNE_W-1:0] o_tune,
  output reg o_valid_flag,
  output wire o_irq,
  // Avalon-MM slave
  input wire [4:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest
);

  // ==========================================
  // Pin synchronisation
  wire [3:0] pins_sync;

  rlhm_sync2 #(
    .W(4)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_crystal_input, i_feedback_input, i_second_reference_in, i_first_reference_in}),
    .o_sync(pins_sync)
  );

  reg [`RLHM_CTRL_REFERENCE_SELECT_BIT:0] ctrl_reg;
  wire ref_sel = ctrl_reg[`RLHM_CTRL_REFERENCE_SELECT_BIT];
  wire [3:0] ratio_sel = ctrl_reg[`RLHM_CTRL_SEL_W-1:0];
  wire ref_now = ref_sel ? pins_sync[0] : pins_sync[1];
  wire fbk_now = pins_sync[2];
  wire xtal_now = pins_sync[3];

  reg ref_d_reg;
  reg fbk_d_reg;
  reg xtal_d_reg;
  wire ref_rise = ref_now & ~ref_d_reg;
  wire fbk_rise = fbk_now & ~fbk_d_reg;
  wire xtal_rise = xtal_now & ~xtal_d_reg;

  // ==========================================
  // Ratio table: reference edges per crystal edge, times 24
  reg [7:0] ratio_x24;
  always @*
  begin
    case (ratio_sel)
      4'h8: ratio_x24 = 8'h30;
      4'hE: ratio_x24 = 8'h90;
      4'h5: ratio_x24 = 8'h13;
      4'hB: ratio_x24 = 8'h48;
      4'h3: ratio_x24 = 8'h08;
      4'h9: ratio_x24 = 8'h18;
      4'hF: ratio_x24 = 8'h60;
      4'hC: ratio_x24 = 8'hC0;
      4'h1: ratio_x24 = 8'h03;
      4'h6: ratio_x24 = 8'h0C;
      4'hD: ratio_x24 = 8'h30;
      4'h4: ratio_x24 = 8'h0C;
      4'hA: ratio_x24 = 8'h24;
      4'h2: ratio_x24 = 8'h04;
      4'h7: ratio_x24 = 8'h12;
      default: ratio_x24 = 8'h00;
    endcase
  end
  wire bypass = (ratio_sel == 4'h0);

  // ==========================================
  // Edge counting over a crystal window
  // Expected count = WIN_XTAL * ratio; WIN_XTAL a multiple of 24 keeps it integral.
  reg [CNT_W-1:0] xwin_reg;
  reg [CNT_W-1:0] refcnt_reg;
  reg [CNT_W-1:0] lastcnt_reg;
  reg win_done_reg;
  // Crystal edges since the last reference edge, for fast loss detection
  reg [7:0] gap_reg;
  wire [15:0] gap_x24 = gap_reg * ratio_x24;
  wire lost = ~bypass && (gap_x24 >= `RLHM_LOSS_X24);
  wire [CNT_W+7:0] exp_x24 = WIN_XTAL[CNT_W-1:0] * ratio_x24;
  wire [CNT_W+7:0] cnt_x24 = lastcnt_reg * 8'h18;
  wire [CNT_W+7:0] tol_x24 = CAP_TOL[CNT_W-1:0] * 8'h18;
  wire in_range = ~bypass && (cnt_x24 + tol_x24 >= exp_x24) && (cnt_x24 <= exp_x24 + tol_x24);

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ref_d_reg <= 1'b0;
      fbk_d_reg <= 1'b0;
      xtal_d_reg <= 1'b0;
      xwin_reg <= {CNT_W{1'b0}};
      refcnt_reg <= {CNT_W{1'b0}};
      lastcnt_reg <= {CNT_W{1'b0}};
      win_done_reg <= 1'b0;
      gap_reg <= 8'h00;
    end
    else
    begin
      if (ref_rise)
        gap_reg <= 8'h00;
      else if (xtal_rise && gap_reg != 8'hFF)
        gap_reg <= gap_reg + 1'b1;
      ref_d_reg <= ref_now;
      fbk_d_reg <= fbk_now;
      xtal_d_reg <= xtal_now;
      win_done_reg <= 1'b0;
      if (xtal_rise && xwin_reg == WIN_XTAL[CNT_W-1:0] - 1'b1)
      begin
        xwin_reg <= {CNT_W{1'b0}};
        lastcnt_reg <= refcnt_reg + {{(CNT_W-1){1'b0}}, ref_rise};
        refcnt_reg <= {CNT_W{1'b0}};
        win_done_reg <= 1'b1;
      end
      else
      begin
        if (xtal_rise)
          xwin_reg <= xwin_reg + 1'b1;
        if (ref_rise && refcnt_reg != {CNT_W{1'b1}})
          refcnt_reg <= refcnt_reg + 1'b1;
      end
    end
  end

  // ==========================================
  // Flag state machine
  localparam ST_FAIL = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_OK = 3'b100;
  reg [2:0] state_reg;
  reg [3:0] good_wins_reg;
  reg [7:0] slack_reg;
  reg ev_fail;
  reg ev_recover;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_reg <= ST_FAIL;
      good_wins_reg <= 4'h0;
      slack_reg <= 8'h00;
      o_valid_flag <= 1'b0;
      ev_fail <= 1'b0;
      ev_recover <= 1'b0;
    end
    else
    begin
      ev_fail <= 1'b0;
      ev_recover <= 1'b0;
      case (state_reg)
        ST_OK:
        begin
          // A dead reference drops the flag within two expected reference periods
          if ((win_done_reg && !in_range) || lost)
          begin
            state_reg <= ST_FAIL;
            o_valid_flag <= 1'b0;
            ev_fail <= 1'b1;
          end
        end
        ST_WAIT:
        begin
          if ((win_done_reg && !in_range) || lost)
          begin
            state_reg <= ST_FAIL;
            good_wins_reg <= 4'h0;
          end
          else if (good_wins_reg >= `RLHM_DEASSERT_MULT)
          begin
            if (slack_reg >= `RLHM_SLACK_CYC)
            begin
              state_reg <= ST_OK;
              o_valid_flag <= 1'b1;
              ev_recover <= 1'b1;
            end
            else
              slack_reg <= slack_reg + 1'b1;
          end
          else if (win_done_reg)
            good_wins_reg <= good_wins_reg + 1'b1;
        end
        ST_FAIL:
        begin
          slack_reg <= 8'h00;
          if (win_done_reg && in_range)
          begin
            state_reg <= ST_WAIT;
            good_wins_reg <= 4'h1;
          end
        end
        default:
        begin
          state_reg <= ST_FAIL;
          o_valid_flag <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Tuning: bang-bang phase detector, frozen outside lock
  // Coarse detector; a real array would want a filtered error.
  reg phase_lead_reg;
  wire steer = (state_reg == ST_OK);
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_tune <= `RLHM_TUNE_MID;
      phase_lead_reg <= 1'b0;
    end
    else
    begin
      if (ref_rise)
        phase_lead_reg <= 1'b1;
      if (fbk_rise)
        phase_lead_reg <= 1'b0;
      if (steer && fbk_rise)
      begin
        // Feedback late: reference already seen, speed up
        if (phase_lead_reg && o_tune != {`RLHM_TUNE_W{1'b1}})
          o_tune <= o_tune + 1'b1;
        else if (!phase_lead_reg && o_tune != {`RLHM_TUNE_W{1'b0}})
          o_tune <= o_tune - 1'b1;
      end
      // Otherwise o_tune holds
    end
  end

  // Loop clock taken from the crystal only, so reference changes never glitch it
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_loop_clk <= 1'b0;
    else
      o_loop_clk <= xtal_now;
  end

  // ==========================================
  // Interrupts
  reg [`RLHM_EVT_W-1:0] evt_stat_reg;
  reg [`RLHM_EVT_W-1:0] evt_en_reg;
  wire [`RLHM_EVT_W-1:0] evt_set = {ev_recover, ev_fail};
  wire wr_clr = i_avs_write && i_avs_address == `RLHM_OFF_EVT_CLR;
  wire [`RLHM_EVT_W-1:0] clr_mask = wr_clr ? i_avs_writedata[`RLHM_EVT_W-1:0] : {`RLHM_EVT_W{1'b0}};
  assign o_irq = |(evt_stat_reg & evt_en_reg);

  // ==========================================
  // Avalon slave: one wait state on reads so registered data stands at the accept edge
  reg rd_ack_reg;
  assign o_avs_waitrequest = i_avs_read & ~rd_ack_reg;
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ctrl_reg <= `RLHM_CTRL_RST_VAL;
      evt_stat_reg <= {`RLHM_EVT_W{1'b0}};
      evt_en_reg <= {`RLHM_EVT_W{1'b0}};
      o_avs_readdata <= 32'h00000000;
      rd_ack_reg <= 1'b0;
    end
    else
    begin
      rd_ack_reg <= i_avs_read & ~rd_ack_reg;
      // Set wins over a simultaneous clear
      evt_stat_reg <= (evt_stat_reg & ~clr_mask) | evt_set;
      if (i_avs_write)
      begin
        if (i_avs_address == `RLHM_OFF_CTRL)
          ctrl_reg <= i_avs_writedata[`RLHM_CTRL_REFERENCE_SELECT_BIT:0];
        if (i_avs_address == `RLHM_OFF_EVT_EN)
          evt_en_reg <= i_avs_writedata[`RLHM_EVT_W-1:0];
      end
      if (i_avs_read && !rd_ack_reg)
      begin
        case (i_avs_address)
          `RLHM_OFF_CTRL: o_avs_readdata <= {27'h0000000, ctrl_reg};
          `RLHM_OFF_STATUS: o_avs_readdata <= {28'h0000000, state_reg, o_valid_flag};
          `RLHM_OFF_TUNE: o_avs_readdata <= {22'h000000, o_tune};
          `RLHM_OFF_COUNT: o_avs_readdata <= {{(32-CNT_W){1'b0}}, lastcnt_reg};
          `RLHM_OFF_EVT_STAT: o_avs_readdata <= {30'h00000000, evt_stat_reg};
          `RLHM_OFF_EVT_EN: o_avs_readdata <= {30'h00000000, evt_en_reg};
          default: o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

//--- tb/rlhm_monitor_sva.sv
`timescale 1ns/1ns
// ==========
// Port checker
module rlhm_monitor_sva #(
  parameter WIN_XTAL = 16,
  parameter CAP_TOL = 2,
  parameter CNT_W = 12
) (
  // Clock, reset and pins
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_first_reference_in,
  input wire i_second_reference_in,
  input wire i_feedback_input,
  input wire i_crystal_input,
  // Outputs
  input wire o_loop_clk,
  input wire [9:0] o_tune,
  input wire o_valid_flag,
  input wire o_irq,
  // Avalon-MM
  input wire [4:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Crystal rises while flag low, and since last reference edge
  reg [15:0] low_x;
  reg [15:0] gap_x;
  always @(posedge i_sys_clk)
  begin
    if (i_rst || o_valid_flag)
      low_x <= 16'h0;
    else if ($rose(i_crystal_input))
      low_x <= low_x + 16'h1;
    if (i_rst || $rose(i_first_reference_in) || $rose(i_second_reference_in))
      gap_x <= 16'h0;
    else if ($rose(i_crystal_input))
      gap_x <= gap_x + 16'h1;
  end
  chk_tune_frozen: assert property (!o_valid_flag && !$past(o_valid_flag) |=> $stable(o_tune))
    else $error("tune moved while invalid");
  chk_tune_step: assert property ($changed(o_tune) |->
    (o_tune == $past(o_tune) + 10'h1) || (o_tune == $past(o_tune) - 10'h1))
    else $error("tune step not one");
  chk_loop_xtal: assert property ($rose(o_loop_clk) |->
    $past(i_crystal_input, 2) || $past(i_crystal_input, 3) || $past(i_crystal_input, 4))
    else $error("loop clock not from crystal");
  chk_wait_low: assert property ((!i_avs_read || $past(o_avs_waitrequest)) |-> !o_avs_waitrequest)
    else $error("waitrequest high too long");
  chk_rd_idle: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("readdata moved when idle");
  chk_flag_hold: assert property ($rose(o_valid_flag) |-> low_x >= 16'd12)
    else $error("flag cleared too early");
  chk_flag_fall: assert property (gap_x > 16'h3 |-> !o_valid_flag)
    else $error("flag late on reference loss");
  chk_irq_clear: assert property (i_avs_write && i_avs_address == 5'h14 &&
    i_avs_writedata[1:0] == 2'h3 |=> !o_irq)
    else $error("irq stays after clear");
endmodule

bind rlhm_monitor rlhm_monitor_sva #(.WIN_XTAL(WIN_XTAL), .CAP_TOL(CAP_TOL), .CNT_W(CNT_W)) u_sva (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_first_reference_in(i_first_reference_in),
  .i_second_reference_in(i_second_reference_in), .i_feedback_input(i_feedback_input),
  .i_crystal_input(i_crystal_input), .o_loop_clk(o_loop_clk), .o_tune(o_tune),
  .o_valid_flag(o_valid_flag), .o_irq(o_irq), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));

//--- tb/rlhm_clk_src.sv
`timescale 1ns/1ns
// ==========
// Crystal, references and board feedback
module rlhm_clk_src (
  // Clock
  input wire i_sys_clk,
  // Control
  input wire i_run,
  input wire i_fast,
  input wire [4:0] i_phase,
  input wire i_loop_clk,
  // Pins
  output reg o_xtal = 1'b0,
  output reg o_first_reference_in = 1'b0,
  output wire o_second_reference_in,
  output wire o_fb
);
  reg [4:0] cnt = 5'h0;
  wire [5:0] ph = {1'b0, cnt} + {1'b0, i_phase};
  // Dead second reference sits at its pull-down level
  assign o_second_reference_in = 1'b0;
  assign o_fb = i_loop_clk;
  always @(posedge i_sys_clk)
  begin
    cnt <= (cnt == 5'h13) ? 5'h0 : cnt + 5'h1;
    o_xtal <= cnt < 5'hA;
    o_first_reference_in <= i_run && (i_fast ? (cnt % 10 < 5) : (ph % 20 < 10));
  end
endmodule

//--- tb/rlhm_monitor_tb_top.sv
`timescale 1ns/1ns
// ==========
// Bench top
module rlhm_monitor_tb_top;
  localparam int WIN = 8;
  localparam int XP = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b1;
  logic fast = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [4:0] adr = 5'h0;
  logic [4:0] ph = 5'h0;
  logic [31:0] wd = 32'h0;
  logic [9:0] held;
  logic [31:0] expq[$];
  wire xtal, r1, r2, fb, lclk, flag, irq, wreq;
  wire [9:0] tune;
  wire [31:0] rdata;
  int fail_count = 0;
  int compares = 0;
  rlhm_monitor #(.WIN_XTAL(WIN)) u_rlhm_monitor (.i_sys_clk(clk), .i_rst(rst),
    .i_first_reference_in(r1), .i_second_reference_in(r2), .i_feedback_input(fb),
    .i_crystal_input(xtal), .o_loop_clk(lclk), .o_tune(tune), .o_valid_flag(flag), .o_irq(irq),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));
  rlhm_clk_src u_rlhm_clk_src (.i_sys_clk(clk), .i_run(run), .i_fast(fast), .i_phase(ph),
    .i_loop_clk(lclk), .o_xtal(xtal), .o_first_reference_in(r1), .o_second_reference_in(r2), .o_fb(fb));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Reads note their expectation; the watcher below compares
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    if (!w)
      expq.push_back(d);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      test_done;
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wflag(input logic v, input int lim);
    int n;
    n = 0;
    while (flag !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= lim)
    begin
      fail_count++;
      test_done;
    end
  endtask
  always @(posedge clk)
  begin
    if (rd === 1'b1 && wreq === 1'b0 && expq.size() > 0)
      chk(rdata, expq.pop_front());
  end
  initial
  begin
    int n;
    n = $urandom(2557);
    ph = 5'($urandom % 20);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 5'h0, 32'h10);
    bus(1'b0, 5'h8, 32'h200);
    bus(1'b0, 5'h4, 32'h2);
    $display("reset test done");
    bus(1'b1, 5'h14, 32'h3);
    bus(1'b1, 5'h18, 32'h3);
    bus(1'b1, 5'h0, 32'h19);
    for (n = 0; flag !== 1'b1 && n < 5000; n++)
      @(negedge clk);
    chk(32'(n >= 12 * XP && n < 5000), 32'h1);
    bus(1'b0, 5'h4, 32'h9);
    bus(1'b0, 5'h10, 32'h2);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    $display("lock test done");
    @(posedge clk);
    run <= 1'b0;
    wflag(1'b0, 2 * XP + 10);
    held = tune;
    repeat (400) @(negedge clk);
    chk(32'(tune), 32'(held));
    bus(1'b0, 5'h10, 32'h3);
    bus(1'b1, 5'h14, 32'h3);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    $display("holdover test done");
    @(posedge clk);
    run <= 1'b1;
    fast <= 1'b1;
    repeat (3000) @(negedge clk);
    chk(32'(flag), 32'h0);
    @(posedge clk);
    fast <= 1'b0;
    wflag(1'b1, 5000);
    chk(32'(flag), 32'h1);
    $display("range test done");
    bus(1'b1, 5'h0, 32'h9);
    wflag(1'b0, 2 * XP + 10);
    chk(32'(flag), 32'h0);
    bus(1'b1, 5'h18, 32'h0);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, 5'h18, 32'h3);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    bus(1'b1, 5'h1C, $urandom);
    bus(1'b0, 5'h1C, 32'h0);
    repeat (3) @(posedge clk);
    $display("select test done");
    test_done;
  end
endmodule
